// >>> mem_map_pkg.sv
// Constants for the on-chip memory subsystem and byte-address decoder.
// Assumes a single 100 MHz core clock; all users refer to names here.
package mem_map_pkg;
  // Clock and access timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int ROM_FIRST_NS = 40;
  localparam int ROM_NEXT_NS = 20;
  localparam logic [2:0] ROM_FIRST_CYC =
    3'((ROM_FIRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] ROM_NEXT_CYC =
    3'((ROM_NEXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] ONE_CYC = 3'h1;
  // Memory sizes
  localparam int RAM_BLOCKS = 8;
  localparam int RAM_BLOCK_WORDS = 4096;
  localparam int ROM_WORDS = 16384;
  localparam int CACHE_SETS = 512;
  localparam int CACHE_WAYS = 2;
  // Byte address map
  localparam logic [23:0] RAM_TOP = 24'h00_FFFF;
  localparam logic [23:0] CE0_BASE = 24'h01_0000;
  localparam logic [23:0] CE1_BASE = 24'h40_0000;
  localparam logic [23:0] CE2_BASE = 24'h80_0000;
  localparam logic [23:0] CE3_BASE = 24'hC0_0000;
  localparam logic [23:0] ROM_BASE = 24'hFF_8000;
  localparam logic [23:0] ROM_TOP = 24'hFF_FFFF;
  // ROM layout
  localparam logic [23:0] REV_ADDR = 24'hFF_ECAE;
  localparam logic [23:0] BRANCH_BASE = 24'hFF_ECB0;
  localparam logic [23:0] SINE_BASE = 24'hFF_ED00;
  localparam logic [23:0] RESERVED_BASE = 24'hFF_EF00;
  localparam logic [23:0] VECTOR_BASE = 24'hFF_FF00;
  // Sine table in Q15
  localparam logic [31:0] Q15_MAX = 32'h0000_7FFF;
  localparam logic [31:0] SINE_HALF = 32'h0000_0080;
  localparam logic [31:0] SINE_DENOM = 32'h0000_5000;
  localparam logic [31:0] SINE_SCALE = 32'h0000_0004;
  // Boot selections that switch the ROM off
  localparam logic [2:0] BOOT_DIRECT16 = 3'h0;
  localparam logic [2:0] BOOT_DIRECT32 = 3'h4;
  // Register offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] BOOT_OFS = 12'h004;
  localparam logic [11:0] PROBE_OFS = 12'h008;
  localparam logic [11:0] CACHE_OFS = 12'h00C;
  // Control field positions
  localparam int CTRL_ROM_OFF_BIT = 0;
  localparam int CTRL_CACHE_EN_BIT = 1;
  localparam int CTRL_FREEZE_BIT = 2;
  localparam int CTRL_FLUSH_BIT = 3;
  localparam int CTRL_WIDTH_LSB = 4;
  // Reset values
  localparam logic ROM_OFF_RESET = 1'h1;
  localparam logic [1:0] WIDTH_RESET = 2'h0;
  // External data width codes
  localparam logic [1:0] WIDTH_32 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_8 = 2'h2;
  localparam logic [21:0] EXT_FULL_MASK = 22'h3F_FFFF;
  // Decoder targets
  typedef enum logic [2:0] {
    TGT_RAM = 3'h0, TGT_ROM = 3'h1, TGT_CE0 = 3'h2,
    TGT_CE1 = 3'h3, TGT_CE2 = 3'h4, TGT_CE3 = 3'h5
  } target_type;
  // Access port states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01, ST_WAIT = 2'b10
  } port_state_type;
endpackage

// >>> onchip_memory_map_decoder.sv
// On-chip RAM, ROM, instruction cache tags and byte-address decoder.
// Assumes core-side access ports and APB run on clk_i; boot pins are async.
`timescale 1ns/1ns
module onchip_memory_map_decoder #(
  parameter logic [15:0] ROM_REVISION = 16'h0001 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Boot pins and core state
  input wire logic [2:0] boot_select_pins_i,
  input wire logic core_held_i,
  input wire logic soft_reset_i,
  // Access ports: 0 program bus, 1 data and DMA buses
  input wire logic [1:0] acc_req_i,
  input wire logic [1:0] acc_we_i,
  input wire logic [1:0] acc_host_i,
  input wire logic [1:0][23:0] acc_addr_i,
  input wire logic [1:0][15:0] acc_wdata_i,
  output logic [1:0] acc_ready_o,
  output logic [1:0] acc_done_o,
  output logic [1:0] acc_err_o,
  output logic [1:0][15:0] acc_rdata_o,
  output logic [1:0][2:0] acc_target_o,
  output logic [1:0] ext_req_o,
  output logic [1:0][21:0] ext_offset_o,
  // Cache lookup results and ROM-disable bit
  output logic cache_hit_o,
  output logic cache_miss_o,
  output logic rom_disable_bit_o,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] prdata_o
);
  // Storage
  logic [15:0] ram_mem [0:mem_map_pkg::RAM_BLOCKS-1]
    [0:mem_map_pkg::RAM_BLOCK_WORDS-1];
  logic [10:0] tag_mem [0:mem_map_pkg::CACHE_SETS*2-1];
  logic [mem_map_pkg::CACHE_SETS*2-1:0] valid_ff;
  logic [mem_map_pkg::CACHE_SETS-1:0] lru_ff;
  // Control and boot state
  logic [2:0] boot_sync1_ff, boot_sync2_ff, boot_pins_ff;
  logic [1:0] boot_cnt_ff;
  logic boot_done_ff;
  logic rom_disable_ff, cache_en_ff, freeze_ff, flush_ff;
  logic [1:0] width_ff;
  logic [23:0] probe_addr_ff;
  logic [15:0] hit_cnt_ff, miss_cnt_ff;
  logic [21:0] ext_mask;
  logic ap_done, ctrl_wr;
  // Per-port combinational views
  logic [1:0] fin_w, cur_we_w, cur_err_w, take_w;
  logic [1:0][23:0] cur_addr_w;
  logic [1:0][15:0] cur_wdata_w;
  mem_map_pkg::target_type cur_tgt_w [0:1];

  // Address decoder: one target per address
  function automatic mem_map_pkg::target_type decode_addr(
    input logic [23:0] a, input logic rom_off);
    if (a <= mem_map_pkg::RAM_TOP) begin
      decode_addr = mem_map_pkg::TGT_RAM;
    end else if (!rom_off && a >= mem_map_pkg::ROM_BASE) begin
      decode_addr = mem_map_pkg::TGT_ROM;
    end else if (a >= mem_map_pkg::CE3_BASE) begin
      decode_addr = mem_map_pkg::TGT_CE3;
    end else if (a >= mem_map_pkg::CE2_BASE) begin
      decode_addr = mem_map_pkg::TGT_CE2;
    end else if (a >= mem_map_pkg::CE1_BASE) begin
      decode_addr = mem_map_pkg::TGT_CE1;
    end else begin
      decode_addr = mem_map_pkg::TGT_CE0;
    end
  endfunction

  // Sine in Q15 from a rational approximation, 256 steps per turn
  function automatic logic [15:0] sine_q15(input logic [7:0] t);
    logic [31:0] u, p, val;
    u = {25'h000_0000, t[6:0]};
    p = u * (mem_map_pkg::SINE_HALF - u);
    val = (mem_map_pkg::Q15_MAX * mem_map_pkg::SINE_SCALE * p)
      / (mem_map_pkg::SINE_DENOM - p);
    sine_q15 = t[7] ? 16'(32'h0000_0000 - val) : val[15:0];
  endfunction

  // Mask ROM contents by region; unlisted regions read as zero
  function automatic logic [15:0] rom_word(input logic [23:0] a);
    logic [23:0] ofs;
    ofs = a - mem_map_pkg::SINE_BASE;
    if (a >= mem_map_pkg::SINE_BASE && a < mem_map_pkg::RESERVED_BASE) begin
      rom_word = sine_q15(ofs[8:1]);
    end else if (a == mem_map_pkg::REV_ADDR) begin
      rom_word = ROM_REVISION;
    end else begin
      rom_word = 16'h0000;
    end
  endfunction

  // Range kept per external space for the chosen data width
  assign ext_mask = mem_map_pkg::EXT_FULL_MASK >> width_ff;

  // Boot pin synchroniser
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_sync1_ff <= 3'h0;
      boot_sync2_ff <= 3'h0;
    end else begin
      boot_sync1_ff <= boot_select_pins_i;
      boot_sync2_ff <= boot_sync1_ff;
    end
  end

  // One-time boot capture after reset release
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_cnt_ff <= 2'h0;
      boot_done_ff <= 1'b0;
      boot_pins_ff <= 3'h0;
    end else if (!boot_done_ff) begin
      boot_cnt_ff <= boot_cnt_ff + 2'h1;
      if (boot_cnt_ff == 2'h2) begin
        boot_done_ff <= 1'b1;
        boot_pins_ff <= boot_sync2_ff;
      end
    end
  end

  // APB handshake: no wait states, registered answer
  assign ap_done = psel_i && penable_i && pready_o;
  assign ctrl_wr = ap_done && pwrite_i && paddr_i == mem_map_pkg::CTRL_OFS;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      if (psel_i && !penable_i) begin
        case (paddr_i)
          mem_map_pkg::CTRL_OFS: prdata_o <= {26'h000_0000, width_ff,
            1'b0, freeze_ff, cache_en_ff, rom_disable_ff};
          mem_map_pkg::BOOT_OFS:
            prdata_o <= {28'h000_0000, boot_done_ff, boot_pins_ff};
          mem_map_pkg::PROBE_OFS: prdata_o <= {5'h00,
            decode_addr(probe_addr_ff, rom_disable_ff), probe_addr_ff};
          mem_map_pkg::CACHE_OFS: prdata_o <= {miss_cnt_ff, hit_cnt_ff};
          default: pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  // Control register; ROM-disable survives soft reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rom_disable_ff <= mem_map_pkg::ROM_OFF_RESET;
      cache_en_ff <= 1'b0;
      freeze_ff <= 1'b0;
      flush_ff <= 1'b0;
      width_ff <= mem_map_pkg::WIDTH_RESET;
      probe_addr_ff <= 24'h00_0000;
    end else begin
      flush_ff <= 1'b0;
      if (!boot_done_ff && boot_cnt_ff == 2'h2) begin
        rom_disable_ff <= boot_sync2_ff == mem_map_pkg::BOOT_DIRECT16 ||
          boot_sync2_ff == mem_map_pkg::BOOT_DIRECT32;
      end else if (ctrl_wr) begin
        rom_disable_ff <= pwdata_i[mem_map_pkg::CTRL_ROM_OFF_BIT];
      end
      if (ctrl_wr) begin
        cache_en_ff <= pwdata_i[mem_map_pkg::CTRL_CACHE_EN_BIT];
        freeze_ff <= pwdata_i[mem_map_pkg::CTRL_FREEZE_BIT];
        flush_ff <= pwdata_i[mem_map_pkg::CTRL_FLUSH_BIT];
        if (pwdata_i[mem_map_pkg::CTRL_WIDTH_LSB +: 2] <= mem_map_pkg::WIDTH_8)
          width_ff <= pwdata_i[mem_map_pkg::CTRL_WIDTH_LSB +: 2];
      end else if (soft_reset_i) begin
        cache_en_ff <= 1'b0;
        freeze_ff <= 1'b0;
      end
      if (ap_done && pwrite_i && paddr_i == mem_map_pkg::PROBE_OFS)
        probe_addr_ff <= pwdata_i[23:0];
    end
  end
  assign rom_disable_bit_o = rom_disable_ff;

  // Helper sequence: no answer for three cycles
  sequence s_quiet3(logic d);
    !d [*3];
  endsequence

  // Access ports, one per bus group
  generate
    for (genvar p = 0; p < 2; p++) begin : g_port
      mem_map_pkg::port_state_type state_ff;
      mem_map_pkg::target_type tgt, tgt_ff;
      logic [2:0] cnt_ff, lat;
      logic [23:0] addr_ff, next_rom_ff;
      logic [15:0] wdata_ff;
      logic we_ff, err_ff, rom_seq_ff, refuse, seq;

      assign tgt = decode_addr(acc_addr_i[p], rom_disable_ff);
      assign refuse = (tgt == mem_map_pkg::TGT_ROM && acc_we_i[p]) ||
        (tgt == mem_map_pkg::TGT_RAM && acc_host_i[p] && core_held_i);
      assign seq = tgt == mem_map_pkg::TGT_ROM && rom_seq_ff &&
        acc_addr_i[p] == next_rom_ff;
      assign lat = (refuse || tgt != mem_map_pkg::TGT_ROM) ?
        mem_map_pkg::ONE_CYC : seq ? mem_map_pkg::ROM_NEXT_CYC :
        mem_map_pkg::ROM_FIRST_CYC;
      assign take_w[p] = acc_ready_o[p] && acc_req_i[p];
      assign fin_w[p] = (take_w[p] && lat == mem_map_pkg::ONE_CYC) ||
        (state_ff == mem_map_pkg::ST_WAIT && cnt_ff == mem_map_pkg::ONE_CYC);
      // Current access: live inputs for single-cycle work, else latched
      always_comb begin
        if (state_ff == mem_map_pkg::ST_IDLE) begin
          cur_addr_w[p] = acc_addr_i[p];
          cur_we_w[p] = acc_we_i[p];
          cur_wdata_w[p] = acc_wdata_i[p];
          cur_err_w[p] = refuse;
          cur_tgt_w[p] = tgt;
        end else begin
          cur_addr_w[p] = addr_ff;
          cur_we_w[p] = we_ff;
          cur_wdata_w[p] = wdata_ff;
          cur_err_w[p] = err_ff;
          cur_tgt_w[p] = tgt_ff;
        end
      end

      // Port sequencing and registered answer
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          state_ff <= mem_map_pkg::ST_IDLE;
          cnt_ff <= 3'h0;
          addr_ff <= 24'h00_0000;
          next_rom_ff <= 24'h00_0000;
          wdata_ff <= 16'h0000;
          we_ff <= 1'b0;
          err_ff <= 1'b0;
          tgt_ff <= mem_map_pkg::TGT_RAM;
          rom_seq_ff <= 1'b0;
          acc_ready_o[p] <= 1'b0;
          acc_done_o[p] <= 1'b0;
          acc_err_o[p] <= 1'b0;
          acc_rdata_o[p] <= 16'h0000;
          acc_target_o[p] <= 3'h0;
          ext_req_o[p] <= 1'b0;
          ext_offset_o[p] <= 22'h00_0000;
        end else begin
          acc_done_o[p] <= fin_w[p];
          acc_err_o[p] <= fin_w[p] && cur_err_w[p];
          ext_req_o[p] <= fin_w[p] && !cur_err_w[p] &&
            cur_tgt_w[p] >= mem_map_pkg::TGT_CE0;
          if (fin_w[p]) begin
            acc_target_o[p] <= cur_tgt_w[p];
            ext_offset_o[p] <= cur_addr_w[p][21:0] & ext_mask;
            if (cur_we_w[p] || cur_err_w[p])
              acc_rdata_o[p] <= 16'h0000;
            else if (cur_tgt_w[p] == mem_map_pkg::TGT_RAM)
              acc_rdata_o[p] <= ram_mem[cur_addr_w[p][15:13]]
                [cur_addr_w[p][12:1]];
            else if (cur_tgt_w[p] == mem_map_pkg::TGT_ROM)
              acc_rdata_o[p] <= rom_word(cur_addr_w[p]);
            else
              acc_rdata_o[p] <= 16'h0000;
          end
          acc_ready_o[p] <= boot_done_ff &&
            !(take_w[p] && lat != mem_map_pkg::ONE_CYC) &&
            !(state_ff == mem_map_pkg::ST_WAIT &&
              cnt_ff != mem_map_pkg::ONE_CYC);
          case (state_ff)
            mem_map_pkg::ST_IDLE: begin
              if (take_w[p]) begin
                addr_ff <= acc_addr_i[p];
                we_ff <= acc_we_i[p];
                wdata_ff <= acc_wdata_i[p];
                err_ff <= refuse;
                tgt_ff <= tgt;
                rom_seq_ff <= tgt == mem_map_pkg::TGT_ROM && !refuse;
                next_rom_ff <= acc_addr_i[p] + 24'h00_0002;
                if (lat != mem_map_pkg::ONE_CYC) begin
                  state_ff <= mem_map_pkg::ST_WAIT;
                  cnt_ff <= lat - mem_map_pkg::ONE_CYC;
                end
              end
            end
            mem_map_pkg::ST_WAIT: begin
              if (cnt_ff == mem_map_pkg::ONE_CYC)
                state_ff <= mem_map_pkg::ST_IDLE;
              else
                cnt_ff <= cnt_ff - mem_map_pkg::ONE_CYC;
            end
            default: state_ff <= mem_map_pkg::ST_IDLE;
          endcase
        end
      end

      // First ROM word answers four cycles after it is taken
      a_rom_first_lat: assert property (@(posedge clk_i) disable iff (rst_i)
        take_w[p] && tgt == mem_map_pkg::TGT_ROM && !refuse && !seq |=>
        s_quiet3(acc_done_o[p]) ##1 acc_done_o[p])
        else $error("ROM first word latency wrong");
      // Sequential ROM word answers after two cycles
      a_rom_next_lat: assert property (@(posedge clk_i) disable iff (rst_i)
        take_w[p] && seq && !refuse |=> !acc_done_o[p] ##1 acc_done_o[p])
        else $error("ROM next word latency wrong");
      // ROM write is answered as an error
      a_rom_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
        take_w[p] && acc_we_i[p] && tgt == mem_map_pkg::TGT_ROM |=>
        acc_done_o[p] && acc_err_o[p])
        else $error("ROM write not refused");
      // Host access to RAM refused while core held
      a_host_refused: assert property (@(posedge clk_i) disable iff (rst_i)
        take_w[p] && acc_host_i[p] && core_held_i &&
        acc_addr_i[p] <= mem_map_pkg::RAM_TOP |=> acc_err_o[p] &&
        acc_rdata_o[p] == 16'h0000)
        else $error("Host RAM access not refused");
      // ROM window goes to space 3 while ROM disabled
      a_rom_absent: assert property (@(posedge clk_i) disable iff (rst_i)
        take_w[p] && rom_disable_ff &&
        acc_addr_i[p] >= mem_map_pkg::ROM_BASE |=> ext_req_o[p] &&
        acc_target_o[p] == mem_map_pkg::TGT_CE3)
        else $error("Disabled ROM still decoded");
      // RAM write on one port reads back two cycles later on it
      a_ram_back: assert property (@(posedge clk_i) disable iff (rst_i)
        take_w[p] && acc_we_i[p] && !refuse &&
        tgt == mem_map_pkg::TGT_RAM && !(take_w[1-p] && acc_we_i[1-p])
        ##1 take_w == 2'b00 ##1 take_w[p] && !acc_we_i[p] &&
        acc_addr_i[p] == $past(acc_addr_i[p], 2) |=>
        acc_rdata_o[p] == $past(acc_wdata_i[p], 3))
        else $error("RAM data not stored");
    end
  endgenerate

  // Dual-access RAM blocks; both ports may hit one block per cycle
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (fin_w[p] && cur_we_w[p] && !cur_err_w[p] &&
          cur_tgt_w[p] == mem_map_pkg::TGT_RAM)
        ram_mem[cur_addr_w[p][15:13]][cur_addr_w[p][12:1]] <=
          cur_wdata_w[p];
    end
  end

  // Cache lookup on external program fetches
  logic [8:0] c_set;
  logic [10:0] c_tag;
  logic c_look, c_hit0, c_hit1, c_fill, c_way;
  assign c_set = acc_addr_i[0][12:4];
  assign c_tag = acc_addr_i[0][23:13];
  assign c_look = take_w[0] && cache_en_ff && !acc_we_i[0] &&
    cur_tgt_w[0] >= mem_map_pkg::TGT_CE0;
  assign c_hit0 = valid_ff[{c_set, 1'b0}] && tag_mem[{c_set, 1'b0}] == c_tag;
  assign c_hit1 = valid_ff[{c_set, 1'b1}] && tag_mem[{c_set, 1'b1}] == c_tag;
  assign c_fill = c_look && !c_hit0 && !c_hit1 && !freeze_ff && !flush_ff;
  assign c_way = lru_ff[c_set];

  // Tag store
  always_ff @(posedge clk_i) begin
    if (c_fill)
      tag_mem[{c_set, c_way}] <= c_tag;
  end

  // Valid, LRU and counters; flush wins over a fill
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_ff <= '0;
      lru_ff <= '0;
      hit_cnt_ff <= 16'h0000;
      miss_cnt_ff <= 16'h0000;
      cache_hit_o <= 1'b0;
      cache_miss_o <= 1'b0;
    end else begin
      cache_hit_o <= c_look && (c_hit0 || c_hit1);
      cache_miss_o <= c_look && !c_hit0 && !c_hit1;
      if (flush_ff) begin
        valid_ff <= '0;
      end else if (c_fill) begin
        valid_ff[{c_set, c_way}] <= 1'b1;
        lru_ff[c_set] <= !c_way;
      end else if (c_look && (c_hit0 || c_hit1) && !freeze_ff) begin
        lru_ff[c_set] <= c_hit0;
      end
      if (soft_reset_i) begin
        hit_cnt_ff <= 16'h0000;
        miss_cnt_ff <= 16'h0000;
      end else if (c_look) begin
        if (c_hit0 || c_hit1)
          hit_cnt_ff <= hit_cnt_ff + 16'h0001;
        else
          miss_cnt_ff <= miss_cnt_ff + 16'h0001;
      end
    end
  end

  // Boot capture sets ROM-disable from the captured pins
  a_boot_rom_off: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(boot_done_ff) |-> rom_disable_ff ==
    (boot_pins_ff == mem_map_pkg::BOOT_DIRECT16 ||
     boot_pins_ff == mem_map_pkg::BOOT_DIRECT32))
    else $error("ROM disable not taken from boot pins");
  // After boot only a control write changes ROM-disable
  a_no_resample: assert property (@(posedge clk_i) disable iff (rst_i)
    boot_done_ff && !ctrl_wr |=> $stable(rom_disable_ff))
    else $error("ROM disable changed without write");
  // Flush empties every line
  a_cache_flush: assert property (@(posedge clk_i) disable iff (rst_i)
    flush_ff |=> valid_ff == '0)
    else $error("Cache flush left valid lines");
  // Frozen cache never gains a line
  a_cache_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    freeze_ff && !ctrl_wr |=> (valid_ff & ~$past(valid_ff)) == '0)
    else $error("Frozen cache was filled");
endmodule

// >>> core_bus_model.sv
// Core bus model: one request at a time on each decoder access port.
// Assumes the decoder answers on the same clock.
`timescale 1ns/1ns
module core_bus_model (
  // Clock
  input wire logic clk_i,
  // Results from the decoder
  input wire logic [1:0] acc_ready_i,
  input wire logic [1:0] acc_done_i,
  input wire logic [1:0] acc_err_i,
  input wire logic [1:0][15:0] acc_rdata_i,
  input wire logic [1:0][2:0] acc_target_i,
  // Requests toward the decoder
  output logic [1:0] acc_req_o = '0,
  output logic [1:0] acc_we_o = '0,
  output logic [1:0] acc_host_o = '0,
  output logic [1:0][23:0] acc_addr_o = '0,
  output logic [1:0][15:0] acc_wdata_o = '0
);
  // Hold the request until taken, then wait for done
  task automatic acc(input int p, input logic w, h, input logic [23:0] a,
    input logic [15:0] d, output logic [15:0] rd, output logic er,
    output logic [2:0] t, output int n);
    n = 0;
    acc_req_o[p] <= 1'b1;
    acc_we_o[p] <= w;
    acc_host_o[p] <= h;
    acc_addr_o[p] <= a;
    acc_wdata_o[p] <= d;
    @(posedge clk_i);
    while (acc_ready_i[p] !== 1'b1) @(posedge clk_i);
    acc_req_o[p] <= 1'b0;
    acc_addr_o[p] <= ~a; // Released address does not keep its value
    do begin
      @(posedge clk_i);
      n++;
    end while (acc_done_i[p] !== 1'b1 && n < 64);
    rd = acc_rdata_i[p];
    er = acc_err_i[p];
    t = acc_target_i[p];
  endtask
endmodule

// >>> tb_onchip_memory_map_decoder.sv
// Testbench: boot capture, address map, ROM timing, RAM, cache, APB.
// Assumes core_bus_model drives the access ports.
`timescale 1ns/1ns
module tb_onchip_memory_map_decoder;
  logic clk_i, rst_i = 1'b1, held = 1'b0, sreset = 1'b0, psel = 1'b0;
  logic penable = 1'b0, pwrite = 1'b0, pready, pslverr, rdis, e0, e1;
  logic [1:0] req, we, host, ready, done, err;
  logic [2:0] boot = 3'h0, t0, t1;
  logic [11:0] paddr = '0;
  logic [15:0] d0, d1;
  logic [31:0] pwdata = '0, prdata, r;
  logic [1:0][23:0] addr;
  logic [1:0][15:0] wdata, rdata;
  logic [1:0][2:0] tgt;
  logic [1:0][21:0] eoff;
  logic [1:0] ereq;
  logic chit, cmiss;
  // Cache set 0 sequence and whether each one hits
  logic [23:0] ca [6] = '{24'h40_0000, 24'h40_2000, 24'h40_0000,
    24'h40_4000, 24'h40_0000, 24'h40_2000};
  logic [5:0] ch = 6'h14;
  int error_cnt = 0, total_checks = 0, cyc = 0, l0, l1;
  // Probe addresses and the target each one selects
  logic [23:0] ta [8] = '{24'h00_0000, 24'h00_FFFE, 24'h01_0000,
    24'h40_0000, 24'h80_0000, 24'hC0_0000, 24'hFF_7FFE, 24'hFF_8000};
  logic [2:0] tt [8] = '{3'h0, 3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5, 3'h1};
  // Design under test
  onchip_memory_map_decoder u_onchip_memory_map_decoder (
    .clk_i(clk_i), .rst_i(rst_i), .boot_select_pins_i(boot),
    .core_held_i(held), .soft_reset_i(sreset), .acc_req_i(req),
    .acc_we_i(we), .acc_host_i(host), .acc_addr_i(addr),
    .acc_wdata_i(wdata), .acc_ready_o(ready), .acc_done_o(done),
    .acc_err_o(err), .acc_rdata_o(rdata), .acc_target_o(tgt),
    .ext_req_o(ereq), .ext_offset_o(eoff), .cache_hit_o(chit),
    .cache_miss_o(cmiss),
    .rom_disable_bit_o(rdis), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata));
  // Core side of the access ports
  core_bus_model u_core_bus_model (.clk_i(clk_i), .acc_ready_i(ready),
    .acc_done_i(done), .acc_err_i(err), .acc_rdata_i(rdata),
    .acc_target_i(tgt), .acc_req_o(req), .acc_we_o(we), .acc_host_o(host),
    .acc_addr_o(addr), .acc_wdata_o(wdata));
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Cut a hang short
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i);
    while (pready !== 1'b1);
    r = prdata;
    e0 = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  // One access on one port
  task automatic ac(input int p, input logic w, h, input logic [23:0] a,
    input logic [15:0] d);
    u_core_bus_model.acc(p, w, h, a, d, d0, e0, t0, l0);
  endtask
  // Verdict
  task automatic end_of_test();
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    for (int b = 0; b < 8; b++) begin
      rst_i <= 1'b1;
      boot <= 3'(b);
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk(32'(rdis), 32'(b == 0 || b == 4));
    end
    boot <= 3'h0;
    sreset <= 1'b1;
    @(posedge clk_i);
    sreset <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(32'(rdis), 32'h0);
    ac(0, 0, 0, 24'hFF_8000, 16'h0);
    chk(32'(l0), 32'h4);
    ac(0, 0, 0, 24'hFF_8002, 16'h0);
    chk(32'(l0), 32'h2);
    ac(1, 0, 0, 24'hFF_ED80, 16'h0);
    chk(32'(d0), mem_map_pkg::Q15_MAX);
    ac(1, 1, 0, 24'hFF_8000, 16'h1234);
    chk(32'(e0), 32'h1);
    for (int i = 0; i < 8; i++) begin
      ac(0, 0, 0, ta[i], 16'h0);
      chk(32'(t0), 32'(tt[i]));
    end
    apb(1, mem_map_pkg::CTRL_OFS, 32'h0000_0001);
    chk(32'(rdis), 32'h1);
    ac(0, 0, 0, 24'hFF_8000, 16'h0);
    chk(32'(t0), 32'h5);
    apb(1, mem_map_pkg::CTRL_OFS, 32'h0000_0002);
    fork
      u_core_bus_model.acc(0, 1, 0, 24'h00_2000, 16'hA5A5, d0, e0, t0, l0);
      u_core_bus_model.acc(1, 1, 0, 24'h00_2002, 16'h5A5A, d1, e1, t1, l1);
    join
    fork
      u_core_bus_model.acc(0, 0, 0, 24'h00_2002, 16'h0, d0, e0, t0, l0);
      u_core_bus_model.acc(1, 1, 0, 24'h00_2000, 16'h1111, d1, e1, t1, l1);
    join
    chk(32'(d0), 32'h0000_5A5A);
    ac(1, 0, 0, 24'h00_2000, 16'h0);
    chk(32'(d0), 32'h0000_1111);
    held <= 1'b1;
    ac(1, 0, 1, 24'h00_0000, 16'h0);
    chk(32'(e0), 32'h1);
    held <= 1'b0;
    apb(0, 12'h010, 32'h0);
    chk(32'(e0), 32'h1);
    ac(0, 0, 0, 24'h40_0000, 16'h0);
    ac(0, 0, 0, 24'h40_0000, 16'h0);
    apb(0, mem_map_pkg::CACHE_OFS, 32'h0);
    chk(r, 32'h0001_0001);
    // Frozen cache takes no new line
    apb(1, mem_map_pkg::CTRL_OFS, 32'h0000_0006);
    for (int i = 0; i < 2; i++) begin
      ac(0, 0, 0, 24'h40_0010, 16'h0);
      chk(32'({chit, cmiss}), 32'h1);
    end
    // Flush, then three tags through the two ways of one set
    apb(1, mem_map_pkg::CTRL_OFS, 32'h0000_000A);
    for (int i = 0; i < 6; i++) begin
      ac(0, 0, 0, ca[i], 16'h0);
      chk(32'({chit, cmiss}), 32'({ch[i], !ch[i]}));
    end
    // Narrow external width masks the offset
    apb(1, mem_map_pkg::CTRL_OFS, 32'h0000_0010);
    ac(0, 0, 0, 24'h7F_FFFE, 16'h0);
    chk(32'(eoff[0]), 32'h001F_FFFE);
    chk(32'(ereq), 32'h1);
    // Probe decode and captured boot pins
    apb(1, mem_map_pkg::PROBE_OFS, 32'h00FF_8000);
    apb(0, mem_map_pkg::PROBE_OFS, 32'h0);
    chk(r, 32'h01FF_8000);
    apb(0, mem_map_pkg::BOOT_OFS, 32'h0);
    chk(r, 32'h0000_000F);
    end_of_test();
  end
endmodule
